/* aqp_top.sv */
`timescale 1ns/100ps
module aqp_top
  #(
  parameter int unsigned FMAX_KHZ = aqp_pkg::FMAX_KHZ_DEF,
  parameter int unsigned RES_TENTHS = aqp_pkg::RES_TENTHS_DEF,
  parameter int unsigned FILT_TICK = aqp_pkg::FILT_TICK_CYC
  )
  (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire aqp_pkg::aqp_sample_s smp,
  input wire logic abs_mode,
  output aqp_pkg::aqp_quad_s quad,
  output logic lagging
  );
  import aqp_pkg::*;

  // ----------------------------------------------------------------
  // Configuration checks
  // ----------------------------------------------------------------

  // Least cycles between two count edges at the chosen ceiling.
  localparam int unsigned GAP_CYC = edge_gap_cyc(FMAX_KHZ);
  // Position in steps needs one bit more than the raw word.
  localparam int STEP_W = POS_W + 1;

  // Only the factory ceilings are accepted.
  if (!(FMAX_KHZ inside {50, 100, 125, 250, 360, 500}))
  begin : g_bad_fmax
    $error("unsupported maximum output frequency");
  end

  // Only the factory resolutions are accepted.
  if (!(RES_TENTHS inside {1, 2, 5}))
  begin : g_bad_res
    $error("unsupported resolution");
  end

  // A zero update interval would stall the low pass for good.
  if (FILT_TICK < 1)
  begin : g_bad_filt_tick
    $error("filter update interval must be at least one cycle");
  end

  // A zero edge gap would wrap the pacer load to all ones and hold edges back for good.
  if (GAP_CYC < 1)
  begin : g_bad_gap_cyc
    $error("edge gap must be at least one cycle");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Converts a position in 0.1 um units to whole resolution steps.
  function automatic logic signed [STEP_W-1:0] to_steps(input logic signed [POS_W-1:0] pos);
    logic signed [STEP_W-1:0] wide;
    wide = {pos[POS_W-1], pos};
    return wide / $signed(STEP_W'(RES_TENTHS));
  endfunction

  // Advances the quadrature phase by one edge in the given direction.
  function automatic aqp_phase_e next_phase(input aqp_phase_e ph, input logic fwd);
    aqp_phase_e nxt;
    nxt = PH_00;
    case (ph)
      PH_00: nxt = fwd ? PH_10 : PH_01;
      PH_10: nxt = fwd ? PH_11 : PH_00;
      PH_11: nxt = fwd ? PH_01 : PH_10;
      PH_01: nxt = fwd ? PH_00 : PH_11;
      default: nxt = PH_00;
    endcase
    return nxt;
  endfunction

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------

  // Measurement path.
  logic signed [POS_W-1:0] filt_pos;
  logic filt_valid;
  logic signed [STEP_W-1:0] target;
  logic in_range_ff;

  // Emitted count and backlog.
  logic signed [STEP_W-1:0] emitted_ff;
  logic signed [STEP_W-1:0] nxt_emitted;
  logic signed [STEP_W:0] backlog;
  logic seeded_ff;

  // Edge pacing.
  logic pace_ready;
  logic step_go;
  logic step_fwd;

  // Quadrature sequencer.
  aqp_phase_e phase_ff;
  aqp_phase_e nxt_phase;
  aqp_quad_s quad_ff;
  aqp_quad_s nxt_quad;

  // Status.
  logic lagging_ff;
  logic nxt_lagging;

  // ----------------------------------------------------------------
  // Measurement path
  // ----------------------------------------------------------------

  // Low pass on the absolute position so fast motion above the corner is dropped.
  aqp_bw_filter #(
    .TICK_CYC(FILT_TICK)
  ) u_filter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .smp(smp),
    .filt_pos(filt_pos),
    .filt_valid(filt_valid)
  );

  // Target edge count from the filtered absolute position.
  assign target = to_steps(filt_pos);

  // Range flag follows each sample; outside it the lines are frozen.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      in_range_ff <= 1'b0;
    else if (smp.valid)
      in_range_ff <= smp.in_range;
  end

  // ----------------------------------------------------------------
  // Start-up and emitted count
  // ----------------------------------------------------------------

  // Difference between where the probe is and what the receiver has seen.
  assign backlog = {target[STEP_W-1], target} - {emitted_ff[STEP_W-1], emitted_ff};

  // Positive backlog means inward motion.
  assign step_fwd = !backlog[STEP_W];

  // An edge goes out when started, in range, paced and behind the target.
  // Below the cap every new step leaves at once, so the edge rate follows
  // the probe speed; above it the pacer holds the rest back as backlog.
  assign step_go = seeded_ff && in_range_ff && pace_ready && (backlog != '0);

  // Start flag, set by the first filtered sample after reset.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      seeded_ff <= 1'b0;
    else if (filt_valid)
      seeded_ff <= 1'b1;
  end

  // The emitted count starts from zero in absolute mode and from the
  // power-on position in incremental mode, so the latter sends nothing at start-up.
  always_comb
  begin
    nxt_emitted = emitted_ff;
    if (!seeded_ff)
    begin
      if (filt_valid)
        nxt_emitted = abs_mode ? '0 : target;
    end
    else if (step_go)
    begin
      // One edge moves the count by one step, so nothing is ever dropped.
      if (step_fwd)
        nxt_emitted = emitted_ff + STEP_W'(1);
      else
        nxt_emitted = emitted_ff - STEP_W'(1);
    end
  end

  // Emitted count register.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      emitted_ff <= '0;
    else
      emitted_ff <= nxt_emitted;
  end

  // ----------------------------------------------------------------
  // Edge pacing
  // ----------------------------------------------------------------

  // Equal edge spacing at the cap keeps both lines on one common period.
  aqp_edge_pacer #(
    .GAP_CYC(GAP_CYC)
  ) u_pacer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .fire(step_go),
    .ready(pace_ready)
  );

  // ----------------------------------------------------------------
  // Quadrature sequencer
  // ----------------------------------------------------------------

  // Phase walks forward for inward motion and backward for outward motion.
  always_comb
  begin
    nxt_phase = phase_ff;
    if (step_go)
      nxt_phase = next_phase(phase_ff, step_fwd);
  end

  // Phase register; reset leaves both lines low.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      phase_ff <= PH_00;
    else
      phase_ff <= nxt_phase;
  end

  // Line levels decoded from the phase; for inward motion the quadrature line trails by a quarter period.
  always_comb
  begin
    nxt_quad = QUAD_RST;
    case (phase_ff)
      PH_00:
      begin
        nxt_quad.a = 1'b0;
        nxt_quad.b = 1'b0;
      end
      PH_10:
      begin
        nxt_quad.a = 1'b1;
        nxt_quad.b = 1'b0;
      end
      PH_11:
      begin
        nxt_quad.a = 1'b1;
        nxt_quad.b = 1'b1;
      end
      PH_01:
      begin
        nxt_quad.a = 1'b0;
        nxt_quad.b = 1'b1;
      end
      default:
      begin
        nxt_quad.a = 1'b0;
        nxt_quad.b = 1'b0;
      end
    endcase
    nxt_quad.a_n = ~nxt_quad.a;
    nxt_quad.b_n = ~nxt_quad.b;
  end

  // The lines are registered so no decode glitch reaches the cable.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      quad_ff <= QUAD_RST;
    else
      quad_ff <= nxt_quad;
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------

  // Counts are owed once started and while behind the target.
  assign nxt_lagging = seeded_ff && (backlog != '0);

  // Raised while counts are still owed to the receiver.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      lagging_ff <= 1'b0;
    else
      lagging_ff <= nxt_lagging;
  end

  // Outputs; there is deliberately no index line.
  assign quad = quad_ff;
  assign lagging = lagging_ff;

endmodule

/* aqp_pkg.sv */
package aqp_pkg;

  // ----------------------------------------------------------------
  // Clock and measurement constants
  // ----------------------------------------------------------------

  // System clock rate in hertz.
  localparam longint unsigned CLK_HZ = 64'd25_000_000;
  // Width of the absolute position word, counted in 0.1 um units.
  localparam int POS_W = 32;
  // Measurement bandwidth in hertz.
  localparam longint unsigned BW_HZ = 64'd100;
  // Two pi scaled by one thousand, for the filter time constant.
  localparam longint unsigned TWO_PI_MILLI = 64'd6283;
  // Filter gain is one over two to this power per update.
  localparam int FILT_SHIFT = 4;
  // Fraction bits carried by the filter accumulator.
  localparam int FILT_FRAC = 8;
  // Cycles between filter updates, set so the corner sits at the bandwidth.
  localparam int unsigned FILT_TICK_CYC =
    32'((CLK_HZ * 64'd1000) / (TWO_PI_MILLI * BW_HZ * (64'd1 << FILT_SHIFT)));

  // ----------------------------------------------------------------
  // Output rate constants
  // ----------------------------------------------------------------

  // Default ceiling of the output signal frequency in kilohertz.
  localparam int unsigned FMAX_KHZ_DEF = 100;
  // Default resolution as a multiple of 0.1 um.
  localparam int unsigned RES_TENTHS_DEF = 1;
  // Count edges that make one full output period.
  localparam longint unsigned EDGES_PER_PERIOD = 64'd4;

  // Least cycles between two count edges, rounded up so the cap holds.
  function automatic int unsigned edge_gap_cyc(input int unsigned fmax_khz);
    longint unsigned edge_hz;
    edge_hz = EDGES_PER_PERIOD * longint'(fmax_khz) * 64'd1000;
    return 32'((CLK_HZ + edge_hz - 64'd1) / edge_hz);
  endfunction

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------

  // Quadrature phase, one-hot, named by the levels of in-phase and quadrature.
  typedef enum logic [3:0] {
    PH_00 = 4'h1,
    PH_10 = 4'h2,
    PH_11 = 4'h4,
    PH_01 = 4'h8
  } aqp_phase_e;

  // One position sample from the sensor front end.
  typedef struct packed {
    logic valid;
    logic in_range;
    logic signed [POS_W-1:0] pos;
  } aqp_sample_s;

  // The four count lines.
  typedef struct packed {
    logic a;
    logic a_n;
    logic b;
    logic b_n;
  } aqp_quad_s;

  // Line levels while idle and in reset.
  localparam aqp_quad_s QUAD_RST = '{a: 1'b0, a_n: 1'b1, b: 1'b0, b_n: 1'b1};

endpackage

/* aqp_bw_filter.sv */
`timescale 1ns/100ps
module aqp_bw_filter
  #(
  parameter int unsigned TICK_CYC = aqp_pkg::FILT_TICK_CYC
  )
  (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire aqp_pkg::aqp_sample_s smp,
  output logic signed [aqp_pkg::POS_W-1:0] filt_pos,
  output logic filt_valid
  );
  import aqp_pkg::*;

  localparam int ACC_W = POS_W + FILT_FRAC;

  logic signed [ACC_W-1:0] acc_ff;
  logic signed [POS_W-1:0] hold_ff;
  logic [31:0] tick_cnt_ff;
  logic seeded_ff;
  logic tick;
  logic signed [ACC_W:0] diff;
  logic signed [ACC_W:0] rounded;

  if (TICK_CYC < 1) begin : g_bad_tick
    $error("filter update interval must be at least one cycle");
  end

  // Update strobe for the first order low pass.
  assign tick = (tick_cnt_ff == 32'h0000_0000);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_ff <= 32'h0000_0000;
    else if (tick)
      tick_cnt_ff <= TICK_CYC - 1;
    else
      tick_cnt_ff <= tick_cnt_ff - 32'h0000_0001;
  end

  // The newest sample is held until the next filter update.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      hold_ff <= '0;
    else if (smp.valid)
      hold_ff <= smp.pos;
  end

  // Step toward the held sample; the accumulator is seeded by the first sample.
  assign diff = {hold_ff[POS_W-1], hold_ff, {FILT_FRAC{1'b0}}} - {acc_ff[ACC_W-1], acc_ff};

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_ff <= '0;
      seeded_ff <= 1'b0;
    end
    else if (!seeded_ff)
    begin
      if (smp.valid)
      begin
        acc_ff <= {smp.pos, {FILT_FRAC{1'b0}}};
        seeded_ff <= 1'b1;
      end
    end
    else if (tick)
      acc_ff <= acc_ff + ACC_W'(diff >>> FILT_SHIFT);
  end

  // Round to whole position units for the output.
  assign rounded = {acc_ff[ACC_W-1], acc_ff} + (ACC_W+1)'(1 << (FILT_FRAC - 1));

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      filt_pos <= '0;
      filt_valid <= 1'b0;
    end
    else
    begin
      filt_pos <= rounded[FILT_FRAC +: POS_W];
      filt_valid <= seeded_ff;
    end
  end

endmodule

/* aqp_edge_pacer.sv */
`timescale 1ns/100ps
module aqp_edge_pacer
  #(
  parameter int unsigned GAP_CYC = 1
  )
  (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic fire,
  output logic ready
  );

  logic [31:0] gap_cnt_ff;

  if (GAP_CYC < 1) begin : g_bad_gap
    $error("edge gap must be at least one cycle");
  end

  // A fired edge blocks the next one for GAP_CYC cycles.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      gap_cnt_ff <= 32'h0000_0000;
    else if (fire)
      gap_cnt_ff <= GAP_CYC - 1;
    else if (gap_cnt_ff != 32'h0000_0000)
      gap_cnt_ff <= gap_cnt_ff - 32'h0000_0001;
  end

  // Ready once the gap has run out.
  assign ready = (gap_cnt_ff == 32'h0000_0000);

endmodule

/* aqp_top_chk.sv */
`timescale 1ns/100ps
module aqp_top_chk
  #(
  parameter int unsigned FMAX_KHZ = aqp_pkg::FMAX_KHZ_DEF,
  parameter int unsigned RES_TENTHS = aqp_pkg::RES_TENTHS_DEF,
  parameter int unsigned FILT_TICK = aqp_pkg::FILT_TICK_CYC
  )
  (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire aqp_pkg::aqp_sample_s smp,
  input wire logic abs_mode,
  input wire aqp_pkg::aqp_quad_s quad,
  input wire logic lagging
  );
  import aqp_pkg::*;
  // Least spacing of two line edges at the configured ceiling.
  localparam int GAP = int'((CLK_HZ + 64'h0000_0fa0 * FMAX_KHZ - 1) / (64'h0000_0fa0 * FMAX_KHZ));
  logic [15:0] gap_ff;
  logic range_ff;
  logic a_ff;
  logic b_ff;
  logic edge_w;
  // An edge is any change of either count line.
  assign edge_w = (quad.a ^ a_ff) | (quad.b ^ b_ff);
  // Cycles since the last edge, saturating so long idles do not wrap.
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      gap_ff <= 16'(GAP);
      a_ff <= 1'b0;
      b_ff <= 1'b0;
    end
    else
    begin
      a_ff <= quad.a;
      b_ff <= quad.b;
      gap_ff <= edge_w ? 16'h0001 : (gap_ff == 16'hffff ? gap_ff : gap_ff + 16'h0001);
    end
  // Range flag of the latest sample taken.
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      range_ff <= 1'b1;
    else if (smp.valid)
      range_ff <= smp.in_range;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_edge;
    edge_w;
  endsequence
  sequence s_out_range;
    !range_ff [*8];
  endsequence
  inv_a_a: assert property (quad.a_n == !quad.a) else $error("a_n is not the inverse of a");
  inv_b_a: assert property (quad.b_n == !quad.b) else $error("b_n is not the inverse of b");
  one_line_a: assert property (!($changed(quad.a) && $changed(quad.b))) else $error("both lines moved");
  edge_gap_a: assert property (s_edge |-> gap_ff >= 16'(GAP)) else $error("edges too close");
  lag_edge_a: assert property (s_edge |-> $past(lagging)) else $error("edge without backlog");
  range_hold_a: assert property (s_out_range |=> $stable(quad)) else $error("edge out of range");
  rst_idle_a: assert property ($rose(rst_n) |-> quad == QUAD_RST && !lagging) else $error("bad idle");
  start_quiet_a: assert property ($rose(rst_n) |-> $stable(quad) [*4]) else $error("early edge");
endmodule
bind aqp_top aqp_top_chk #(.FMAX_KHZ(FMAX_KHZ), .RES_TENTHS(RES_TENTHS), .FILT_TICK(FILT_TICK)) i_chk
  (.clk_sys(clk_sys), .rst_n(rst_n), .smp(smp), .abs_mode(abs_mode), .quad(quad), .lagging(lagging));

/* aqp_rx_model.sv */
`timescale 1ns/100ps
module aqp_rx_model
  (
  input wire logic clk_sys,
  input wire logic clr_n,
  input wire aqp_pkg::aqp_quad_s quad,
  output logic signed [31:0] count,
  output logic fault
  );
  import aqp_pkg::*;
  logic [1:0] prev_ff;
  // Gray index of the line pair in inward order 00, 10, 11, 01.
  function automatic logic [1:0] idx(input logic a, input logic b);
    return {b, a ^ b};
  endfunction
  // Counts every edge of both lines; a jump of two states is a fault.
  always @(posedge clk_sys or negedge clr_n)
    if (!clr_n)
    begin
      count <= 32'h0000_0000;
      fault <= 1'b0;
      prev_ff <= 2'h0;
    end
    else
    begin
      case (2'(idx(quad.a, quad.b) - prev_ff))
        2'h1: count <= count + 32'h0000_0001;
        2'h3: count <= count - 32'h0000_0001;
        2'h2: fault <= 1'b1;
        default: ;
      endcase
      if (quad.a_n === quad.a || quad.b_n === quad.b)
        fault <= 1'b1;
      prev_ff <= idx(quad.a, quad.b);
    end
endmodule

/* aqp_top_tb.sv */
`timescale 1ns/100ps
module aqp_top_tb;
  import aqp_pkg::*;
  localparam int unsigned FMAX = 500;
  localparam int unsigned RES = 2;
  logic clk_sys;
  logic rst_n;
  aqp_sample_s smp;
  logic abs_mode;
  aqp_quad_s quad;
  logic lagging;
  logic signed [31:0] rx_count;
  logic rx_fault;
  int n_errors;
  int samples_checked;
  int model_start;
  int targets[$];
  int t;
  // ----------------------------------------------------------------
  // Design, receiving counter and clock
  // ----------------------------------------------------------------
  aqp_top #(.FMAX_KHZ(FMAX), .RES_TENTHS(RES), .FILT_TICK(1)) i_dut
    (.clk_sys(clk_sys), .rst_n(rst_n), .smp(smp), .abs_mode(abs_mode), .quad(quad), .lagging(lagging));
  aqp_rx_model i_rx (.clk_sys(clk_sys), .clr_n(rst_n), .quad(quad), .count(rx_count), .fault(rx_fault));
  // Free-running system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Samples arrive on three clocks out of four on average.
  always @(posedge clk_sys)
    smp.valid <= ($urandom % 4) != 0;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Odd positions keep the step count clear of filter rounding.
  task automatic move(input int step, input logic inr);
    @(posedge clk_sys);
    smp.pos <= 32'(step * int'(RES) + 1);
    smp.in_range <= inr;
    targets.push_back(step);
  endtask
  task automatic do_reset(input logic am, input int step);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    abs_mode <= am;
    move(step, 1'b1);
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    model_start = am ? 0 : step;
  endtask
  // Waits for the counter to reach the model count, then lets it rest.
  task automatic settle();
    int i;
    int exp;
    exp = targets[$] - model_start;
    i = 0;
    while (rx_count !== 32'(exp) && i < 20000)
    begin
      @(posedge clk_sys);
      i++;
    end
    if (rx_count !== 32'(exp))
    begin
      check("rx_count", rx_count, 32'(exp));
      finish_test();
    end
    repeat (300) @(posedge clk_sys);
    check("rx_count", rx_count, 32'(exp));
    check("lagging", {31'h0, lagging}, 32'h0000_0000);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hca3e_c7d1));
    rst_n = 1'b0;
    abs_mode = 1'b1;
    smp = '0;
    n_errors = 0;
    samples_checked = 0;
    do_reset(1'b1, 100);
    settle();
    move(300, 1'b1);
    settle();
    move(50, 1'b1);
    settle();
    move(200, 1'b0);
    repeat (3000) @(posedge clk_sys);
    check("rx_count", rx_count, 32'h0000_0032);
    smp.in_range <= 1'b1;
    settle();
    move(400, 1'b1);
    repeat (500) @(posedge clk_sys);
    move(10, 1'b1);
    settle();
    repeat (4)
    begin
      t = $urandom_range(400, 0);
      move(t, 1'b1);
      settle();
    end
    // Slow ramp, one step per 200 clocks, well below the cap: the count tracks the motion.
    t = targets[$];
    repeat (20)
    begin
      t++;
      move(t, 1'b1);
      repeat (200) @(posedge clk_sys);
      check("rx_count", rx_count, 32'(t));
    end
    do_reset(1'b0, 500);
    repeat (2000) @(posedge clk_sys);
    check("rx_count", rx_count, 32'h0000_0000);
    move(520, 1'b1);
    settle();
    check("rx_fault", {31'h0, rx_fault}, 32'h0000_0000);
    finish_test();
  end
endmodule
